// ==== logic/clk_ctrl_pkg.sv ====
// Purpose: Shared constants of the clock generation controller.
// Assumes: 100 MHz core clock, byte addresses on a 32-bit APB.
// Notes: Oscillator rates are modelled as enable pulses of the core clock.
package clk_ctrl_pkg;
	// ****************************************
	// Register byte addresses
	// ****************************************
	localparam logic [31:0] ADDR_PROT = 32'hfffff800;
	localparam logic [31:0] ADDR_PCC = 32'hfffff828;
	localparam logic [31:0] ADDR_MULT = 32'hfffff82c;
	localparam logic [31:0] ADDR_IOSC = 32'hfffff830;
	localparam logic [31:0] ADDR_CKC = 32'hfffff834;
	localparam logic [31:0] ADDR_OPST = 32'hfffff838;
	localparam logic [31:0] ADDR_OUTCTL = 32'hfffff83c;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int PCC_SUB_FB = 7;
	localparam int PCC_MAIN_STOP = 6;
	localparam int PCC_MAIN_FB = 5;
	localparam int PCC_SRC_STAT = 4;
	localparam int PCC_SUB_SEL = 3;
	localparam int MULT_START = 0;
	localparam int MULT_MODE = 1;
	localparam int IOSC_STOP = 0;
	localparam int CKC_FACTOR = 0;
	localparam int OPST_ON_INT = 0;
	localparam int OUTCTL_EN = 0;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] PCC_RST = 8'h03;
	localparam logic [7:0] MULT_RST = 8'h01;
	localparam logic [7:0] IOSC_RST = 8'h00;
	localparam logic [7:0] CKC_RST = 8'h0a;
	localparam logic [7:0] OUTCTL_RST = 8'h00;
	// ****************************************
	// Rates and times
	// ****************************************
	localparam int CORE_HZ = 100_000_000;
	localparam int MAIN_OSC_HZ = 2_500_000;
	localparam int SUB_HZ = 32_768;
	localparam int WATCH_HZ = 32_768;
	localparam int INT_OSC_HZ = 200_000;
	localparam int LOCK_TIME_US = 100;
	localparam logic [15:0] MAIN_OSC_CYC = 16'(CORE_HZ / MAIN_OSC_HZ);
	localparam logic [15:0] PLL_X4_CYC = 16'(CORE_HZ / (MAIN_OSC_HZ * 4));
	localparam logic [15:0] PLL_X8_CYC = 16'(CORE_HZ / (MAIN_OSC_HZ * 8));
	localparam logic [15:0] SUB_CYC = 16'(CORE_HZ / SUB_HZ);
	localparam logic [15:0] INT_OSC_CYC = 16'(CORE_HZ / INT_OSC_HZ);
	localparam logic [15:0] WATCH_DIV = 16'(MAIN_OSC_HZ / WATCH_HZ);
	localparam int LOCK_CYC = LOCK_TIME_US * (CORE_HZ / 1_000_000);
	localparam logic [2:0] DIV_LAST_CODE = 3'h5;
endpackage

// ==== logic/clk_tick_if.sv ====
// Purpose: Ticks and selection state passed to the system clock prescaler.
// Assumes: All members are single-cycle enables or levels on core_clk.
// Notes: None.
`timescale 1ns/1ps
interface clk_tick_if;
	logic fxx_tick;
	logic sub_tick;
	logic int_tick;
	logic on_sub;
	logic on_int;
	logic [2:0] div_code;
	logic fclk_tick;
	modport ctrl(output fxx_tick, sub_tick, int_tick, on_sub, on_int, div_code, input fclk_tick);
	modport presc(input fxx_tick, sub_tick, int_tick, on_sub, on_int, div_code, output fclk_tick);
endinterface

// ==== logic/rate_divider.sv ====
// Purpose: Counts step pulses and emits one tick per period.
// Assumes: period is at least 1.
// Notes: Dropping run clears the count, so a stopped source restarts cleanly.
`timescale 1ns/1ps
module rate_divider #(
	parameter int W = 16
) (
	input wire logic core_clk, // Core clock
	input wire logic srst, // Synchronous reset
	input wire logic run, // Source oscillating
	input wire logic step, // Count enable
	input wire logic [W-1:0] period, // Steps per tick
	output logic tick // One-cycle tick
);
	logic [W-1:0] cnt;
	wire wrap = cnt >= period - W'(1);

	always_ff @(posedge core_clk) begin
		if (srst || !run) begin
			cnt <= '0;
			tick <= 1'b0;
		end else begin
			tick <= step && wrap;
			if (step) begin
				cnt <= wrap ? '0 : cnt + W'(1);
			end
		end
	end
endmodule

// ==== logic/sysclk_prescaler.sv ====
// Purpose: Divides the main clock by 1 to 32 and selects the system clock.
// Assumes: Codes above the last divider select no clock.
// Notes: The selector follows the switched source status, not the select bit.
`timescale 1ns/1ps
module sysclk_prescaler (
	input wire logic core_clk, // Core clock
	input wire logic srst, // Synchronous reset
	clk_tick_if.presc sel // Ticks in, system tick out
);
	import clk_ctrl_pkg::*;

	logic [4:0] cnt;
	logic [7:0] div_tick;
	wire code_ok = sel.div_code <= DIV_LAST_CODE;
	wire main_pick = code_ok && div_tick[sel.div_code];
	wire pick = sel.on_int ? sel.int_tick : (sel.on_sub ? sel.sub_tick : main_pick);

	assign div_tick[0] = sel.fxx_tick;
	assign div_tick[7:6] = 2'b00;
	for (genvar i = 1; i < 6; i++) begin : g_div
		assign div_tick[i] = sel.fxx_tick && (&cnt[i-1:0]);
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			cnt <= '0;
			sel.fclk_tick <= 1'b0;
		end else begin
			if (sel.fxx_tick) begin
				cnt <= cnt + 5'h01;
			end
			sel.fclk_tick <= pick;
		end
	end
endmodule

// ==== logic/clock_gen_ctrl.sv ====
// Purpose: Clock generation control with APB register access.
// Assumes: Oscillators run as enable pulses; stop_mode and wdt_stab_overflow are on core_clk.
// Notes: Registers answer with no wait state, pready high in the first access-phase cycle.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module clock_gen_ctrl #(
	parameter int LOCK_CYCLES = clk_ctrl_pkg::LOCK_CYC
) (
	input wire logic core_clk, // 100 MHz clock
	input wire logic srst, // Synchronous reset
	input wire logic [31:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [3:0] pstrb, // APB byte strobes
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic stop_mode, // Device in stop mode
	input wire logic wdt_stab_overflow, // Watchdog overflow in stabilisation
	output logic fxx_clk_en, // Main clock tick
	output logic sys_clk_en, // System clock tick
	output logic cpu_clk_en, // CPU clock tick
	output logic watch_clk_en, // 32.768 kHz watch tick
	output logic sub_clk_en, // Subclock tick
	output logic sub_feedback_resistor_off, // Sub resistor off
	output logic main_feedback_resistor_off, // Main resistor off
	output logic main_osc_enable, // Main oscillator runs
	output logic internal_osc_enable, // Internal oscillator runs
	output logic multiplier_locked, // Multiplier lock reached
	output logic clock_output_pin, // System clock out
	output logic clock_output_pin_oe_n // Pin drive enable, low drives
);
	import clk_ctrl_pkg::*;

	// ****************************************
	// Registers and state
	// ****************************************
	logic [7:0] processor_clock_control;
	logic [7:0] multiplier_control;
	logic [7:0] internal_osc_mode;
	logic [7:0] clock_divider_control;
	logic [7:0] out_ctl;
	logic prot_armed;
	logic running_on_internal_osc;
	logic [31:0] lock_cnt;
	logic fx_tick;
	logic fxx_tick;
	logic sub_tick;
	logic int_tick;
	logic watch_tick;

	clk_tick_if sel_if();

	// ****************************************
	// Bus decode
	// ****************************************
	wire setup = psel && !penable;
	wire acc_done = psel && penable && pready;
	wire wr_done = acc_done && pwrite;
	wire wr_lane = pstrb[0];
	wire hit_prot = paddr == ADDR_PROT;
	wire hit_pcc = paddr == ADDR_PCC;
	wire hit_mult = paddr == ADDR_MULT;
	wire hit_iosc = paddr == ADDR_IOSC;
	wire hit_ckc = paddr == ADDR_CKC;
	wire hit_opst = paddr == ADDR_OPST;
	wire hit_outctl = paddr == ADDR_OUTCTL;
	wire mapped = hit_prot || hit_pcc || hit_mult || hit_iosc || hit_ckc || hit_opst || hit_outctl;
	wire [7:0] wbyte = pwdata[7:0];

	// Protected registers take a write only while armed
	wire wr_pcc = wr_done && wr_lane && hit_pcc && prot_armed;
	wire wr_ckc = wr_done && wr_lane && hit_ckc && prot_armed;
	wire wr_prot = wr_done && wr_lane && hit_prot;
	wire wr_mult = wr_done && wr_lane && hit_mult;
	wire wr_iosc = wr_done && wr_lane && hit_iosc;
	wire wr_outctl = wr_done && wr_lane && hit_outctl;

	// ****************************************
	// Clock status decode
	// ****************************************
	wire on_sub = processor_clock_control[PCC_SRC_STAT];
	wire sub_req = processor_clock_control[PCC_SUB_SEL];
	// Stop request is honoured only once the CPU is off the main clock
	wire main_run = !stop_mode && !(processor_clock_control[PCC_MAIN_STOP] && on_sub);
	wire int_run = !internal_osc_mode[IOSC_STOP] || running_on_internal_osc;
	wire mult_on = multiplier_control[MULT_START] && main_run;
	wire locked = mult_on && (lock_cnt >= 32'(LOCK_CYCLES));
	wire mult_mode = multiplier_control[MULT_MODE];
	wire [15:0] fxx_period = !mult_mode ? MAIN_OSC_CYC
		: (clock_divider_control[CKC_FACTOR] ? PLL_X8_CYC : PLL_X4_CYC);
	wire fxx_run = main_run && (!mult_mode || locked);

	// Source switch lands on a subclock edge, within one subclock period
	wire switch_now = sub_tick && (sub_req != on_sub);
	// Bit 4 of the written byte is dropped; a switch in the same cycle still lands
	wire [7:0] pcc_wr_val = {wbyte[7:5], switch_now ? sub_req : on_sub, wbyte[3:0]};
	// Clearing start pulls the mode bit down; mode rises only when locked
	wire [7:0] mult_wr_val = {6'h00, wbyte[MULT_MODE] && wbyte[MULT_START] && locked, wbyte[MULT_START]};

	wire [7:0] rd_byte = hit_pcc ? processor_clock_control
		: hit_mult ? multiplier_control
		: hit_iosc ? internal_osc_mode
		: hit_ckc ? clock_divider_control
		: hit_opst ? {7'h00, running_on_internal_osc}
		: hit_outctl ? out_ctl
		: 8'h00;

	// ****************************************
	// Oscillator and multiplier dividers
	// ****************************************
	rate_divider #(.W(16)) u_fx (
		.core_clk(core_clk),
		.srst(srst),
		.run(main_run),
		.step(1'b1),
		.period(MAIN_OSC_CYC),
		.tick(fx_tick)
	);

	rate_divider #(.W(16)) u_fxx (
		.core_clk(core_clk),
		.srst(srst),
		.run(fxx_run),
		.step(1'b1),
		.period(fxx_period),
		.tick(fxx_tick)
	);

	rate_divider #(.W(16)) u_sub (
		.core_clk(core_clk),
		.srst(srst),
		.run(1'b1),
		.step(1'b1),
		.period(SUB_CYC),
		.tick(sub_tick)
	);

	rate_divider #(.W(16)) u_int (
		.core_clk(core_clk),
		.srst(srst),
		.run(int_run),
		.step(1'b1),
		.period(INT_OSC_CYC),
		.tick(int_tick)
	);

	// Watch clock counts main oscillator ticks, not the multiplied clock
	rate_divider #(.W(16)) u_watch (
		.core_clk(core_clk),
		.srst(srst),
		.run(main_run),
		.step(fx_tick),
		.period(WATCH_DIV),
		.tick(watch_tick)
	);

	// ****************************************
	// System clock selection
	// ****************************************
	assign sel_if.fxx_tick = fxx_tick;
	assign sel_if.sub_tick = sub_tick;
	assign sel_if.int_tick = int_tick;
	assign sel_if.on_sub = on_sub;
	assign sel_if.on_int = running_on_internal_osc;
	assign sel_if.div_code = processor_clock_control[2:0];

	sysclk_prescaler u_presc (
		.core_clk(core_clk),
		.srst(srst),
		.sel(sel_if.presc)
	);

	// ****************************************
	// APB slave
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (srst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup;
			pslverr <= setup && !mapped;
			prdata <= (setup && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
		end
	end

	// Any other write consumes the unlock, so it covers one write only
	always_ff @(posedge core_clk) begin
		if (srst) begin
			prot_armed <= 1'b0;
		end else if (wr_done) begin
			prot_armed <= wr_prot;
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (srst) begin
			processor_clock_control <= PCC_RST;
		end else if (wr_pcc) begin
			processor_clock_control <= pcc_wr_val;
		end else if (switch_now) begin
			processor_clock_control[PCC_SRC_STAT] <= sub_req;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			multiplier_control <= MULT_RST;
			clock_divider_control <= CKC_RST;
			internal_osc_mode <= IOSC_RST;
			out_ctl <= OUTCTL_RST;
		end else begin
			if (wr_mult) begin
				multiplier_control <= mult_wr_val;
			end
			if (wr_ckc) begin
				clock_divider_control <= wbyte;
			end
			if (wr_iosc) begin
				internal_osc_mode <= {7'h00, wbyte[IOSC_STOP]};
			end
			if (wr_outctl) begin
				out_ctl <= {7'h00, wbyte[OUTCTL_EN]};
			end
		end
	end

	// Flag only rises; nothing on the bus clears it
	always_ff @(posedge core_clk) begin
		if (srst) begin
			running_on_internal_osc <= 1'b0;
		end else if (wdt_stab_overflow) begin
			running_on_internal_osc <= 1'b1;
		end
	end

	// Lock time restarts whenever the multiplier stops or loses its source
	always_ff @(posedge core_clk) begin
		if (srst || !mult_on) begin
			lock_cnt <= 32'h00000000;
		end else if (!locked) begin
			lock_cnt <= lock_cnt + 32'h00000001;
		end
	end

	// ****************************************
	// Clock outputs
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (srst) begin
			fxx_clk_en <= 1'b0;
			sys_clk_en <= 1'b0;
			cpu_clk_en <= 1'b0;
			watch_clk_en <= 1'b0;
			sub_clk_en <= 1'b0;
			main_osc_enable <= 1'b0;
			internal_osc_enable <= 1'b0;
			multiplier_locked <= 1'b0;
		end else begin
			fxx_clk_en <= fxx_tick;
			sys_clk_en <= sel_if.fclk_tick && !stop_mode;
			cpu_clk_en <= sel_if.fclk_tick && !stop_mode;
			watch_clk_en <= watch_tick;
			sub_clk_en <= sub_tick;
			main_osc_enable <= main_run;
			internal_osc_enable <= int_run;
			multiplier_locked <= locked;
		end
	end

	// Feedback resistor controls mirror the register bits
	assign sub_feedback_resistor_off = processor_clock_control[PCC_SUB_FB];
	assign main_feedback_resistor_off = processor_clock_control[PCC_MAIN_FB];

	// Pin toggles once per system tick; it sits low when disabled or in stop mode
	always_ff @(posedge core_clk) begin
		if (srst) begin
			clock_output_pin <= 1'b0;
			clock_output_pin_oe_n <= 1'b1;
		end else begin
			clock_output_pin_oe_n <= !out_ctl[OUTCTL_EN];
			if (!out_ctl[OUTCTL_EN] || stop_mode) begin
				clock_output_pin <= 1'b0;
			end else if (sel_if.fclk_tick) begin
				clock_output_pin <= !clock_output_pin;
			end
		end
	end
endmodule

// ==== dv/clock_gen_ctrl_checker.sv ====
// Purpose: Port-level assertions for the clock generation controller.
// Assumes: One core_clk domain, synchronous active-high reset.
// Notes: Lock bound counts from reset release, a safe lower limit.
`timescale 1ns/1ps
module clock_gen_ctrl_checker import clk_ctrl_pkg::*; #(
	parameter int LOCK_CYCLES = 20
) (
	input wire logic core_clk, // Clock
	input wire logic srst, // Reset
	input wire logic psel, // APB
	input wire logic penable, // APB
	input wire logic [31:0] prdata, // APB
	input wire logic pready, // APB
	input wire logic pslverr, // APB
	input wire logic stop_mode, // Stop request
	input wire logic sys_clk_en, // System tick
	input wire logic cpu_clk_en, // CPU tick
	input wire logic sub_feedback_resistor_off, // Resistor
	input wire logic main_feedback_resistor_off, // Resistor
	input wire logic main_osc_enable, // Main osc
	input wire logic multiplier_locked, // Lock
	input wire logic clock_output_pin, // Pin
	input wire logic clock_output_pin_oe_n // Pin enable
);
	// ****************************************
	// Helpers
	// ****************************************
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	logic [15:0] since_rst;
	always_ff @(posedge core_clk) begin
		if (srst)
			since_rst <= 16'h0;
		else if (since_rst != 16'hffff)
			since_rst <= since_rst + 16'h1;
	end
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence quiet_pin_s;
		clock_output_pin_oe_n [*2];
	endsequence
	// ****************************************
	// Assertions
	// ****************************************
	a_ready_after_setup: assert property (setup_s |=> pready) else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
	a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("data outside access");
	a_byte_wide_read: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper data set");
	a_lock_not_early: assert property (multiplier_locked |-> since_rst >= LOCK_CYCLES) else $error("lock early");
	a_stop_halts_main: assert property (stop_mode [*2] |-> !main_osc_enable) else $error("main runs in stop");
	a_stop_no_sys: assert property (stop_mode [*4] |-> !sys_clk_en) else $error("system tick in stop");
	a_sys_cpu_equal: assert property (sys_clk_en == cpu_clk_en) else $error("cpu and system ticks differ");
	a_pin_low_idle: assert property (quiet_pin_s |-> !clock_output_pin) else $error("pin toggles disabled");
	a_resistor_steady: assert property (!$past(pready) |-> $stable(sub_feedback_resistor_off)
		&& $stable(main_feedback_resistor_off)) else $error("resistor moved without write");
endmodule

bind clock_gen_ctrl clock_gen_ctrl_checker #(.LOCK_CYCLES(LOCK_CYCLES)) chk (.core_clk, .srst, .psel, .penable,
	.prdata, .pready, .pslverr, .stop_mode, .sys_clk_en, .cpu_clk_en, .sub_feedback_resistor_off,
	.main_feedback_resistor_off, .main_osc_enable, .multiplier_locked, .clock_output_pin, .clock_output_pin_oe_n);

// ==== dv/cpu_clock_source_selector_tb.sv ====
// Purpose: Self-checking bench for the clock generation controller.
// Assumes: Read results queued by the driver, compared by a monitor.
// Notes: Short lock count keeps the run brief.
`timescale 1ns/1ps
module cpu_clock_source_selector_tb;
	import clk_ctrl_pkg::*;
	logic core_clk, srst, psel, penable, pwrite, stop_mode, wdt_stab_overflow;
	logic [31:0] paddr, pwdata, prdata;
	logic [3:0] pstrb;
	logic pready, pslverr, fxx_clk_en, sys_clk_en, cpu_clk_en, watch_clk_en, sub_clk_en;
	logic sub_feedback_resistor_off, main_feedback_resistor_off, main_osc_enable, internal_osc_enable;
	logic multiplier_locked, clock_output_pin, clock_output_pin_oe_n;
	logic [3:0] ticks;
	logic pin_prev;
	logic [8:0] exp_q[$];
	int n_fail = 0;
	int samples_checked = 0;
	assign ticks = {sub_clk_en, watch_clk_en, sys_clk_en, fxx_clk_en};
	clock_gen_ctrl #(.LOCK_CYCLES(20)) dut (.core_clk, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .stop_mode, .wdt_stab_overflow, .fxx_clk_en, .sys_clk_en, .cpu_clk_en,
		.watch_clk_en, .sub_clk_en, .sub_feedback_resistor_off, .main_feedback_resistor_off, .main_osc_enable,
		.internal_osc_enable, .multiplier_locked, .clock_output_pin, .clock_output_pin_oe_n);
	// ****************************************
	// Tasks
	// ****************************************
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task apb(input logic [31:0] a, input logic w, input logic [7:0] d, input logic [8:0] e);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h0, d};
		if (!w)
			exp_q.push_back(e);
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			chk("pready", 1, 0);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [31:0] a, input logic [8:0] e);
		apb(a, 1'b0, 8'h00, e);
	endtask
	task wr(input logic [31:0] a, input logic [7:0] d);
		apb(a, 1'b1, d, 9'h0);
	endtask
	task pwr(input logic [31:0] a, input logic [7:0] d);
		wr(ADDR_PROT, 8'($urandom));
		wr(a, d);
	endtask
	// Third interval only, so a source switch in flight does not count
	task gap(input int k, input int e);
		int n;
		n = 0;
		for (int i = 0; i < 3; i++) begin
			n = 0;
			do begin
				@(posedge core_clk);
				n++;
			end while (ticks[k] !== 1'b1 && n < 8000);
		end
		chk("tick_gap", e, n);
	endtask
	task end_of_test;
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ****************************************
	// Read monitor and watchdog
	// ****************************************
	always @(posedge core_clk) begin
		if (psel && penable && pready && !pwrite && exp_q.size() > 0)
			chk("read", {23'h0, exp_q.pop_front()}, {23'h0, pslverr, prdata[7:0]});
	end
	initial begin
		#1_000_000;
		n_fail++;
		end_of_test();
	end
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		int n;
		{srst, psel, penable, pwrite, stop_mode, wdt_stab_overflow} = 6'b100000;
		paddr = 32'h0;
		pwdata = 32'h0;
		pstrb = 4'hf;
		void'($urandom(38));
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		rd(ADDR_PCC, 9'h003);
		rd(ADDR_MULT, {1'b0, MULT_RST});
		rd(ADDR_IOSC, 9'h000);
		rd(ADDR_CKC, {1'b0, CKC_RST});
		rd(ADDR_OPST, 9'h000);
		rd(32'hfffff810, 9'h100);
		wr(ADDR_PCC, 8'h01);
		rd(ADDR_PCC, 9'h003);
		wr(ADDR_MULT, 8'h00);
		pwr(ADDR_PCC, 8'hf1);
		rd(ADDR_PCC, 9'h0e1);
		chk("resistors", 2'b11, {sub_feedback_resistor_off, main_feedback_resistor_off});
		chk("main_run", 1, main_osc_enable);
		// Restart early so the lock time is over before the mode bit is set
		wr(ADDR_MULT, 8'h01);
		gap(1, 2 * MAIN_OSC_CYC);
		wr(ADDR_PROT, 8'h00);
		wr(ADDR_IOSC, 8'h00);
		wr(ADDR_PCC, 8'h00);
		rd(ADDR_PCC, 9'h0e1);
		wr(ADDR_MULT, 8'h03);
		rd(ADDR_MULT, 9'h003);
		chk("locked", 1, multiplier_locked);
		gap(0, PLL_X4_CYC);
		pwr(ADDR_CKC, 8'h0b);
		gap(0, PLL_X8_CYC);
		for (int c = 0; c < 8; c++) begin
			pwr(ADDR_PCC, 8'(c));
			if (c < 6) begin
				gap(1, int'(PLL_X8_CYC) << c);
			end else begin
				n = 0;
				// Ticks already in the selector pipeline belong to the old code
				repeat (3) @(posedge core_clk);
				repeat (1000) begin
					@(posedge core_clk);
					n += int'(sys_clk_en);
				end
				chk("prohibited", 0, n);
			end
		end
		pwr(ADDR_PCC, 8'h01);
		wr(ADDR_MULT, 8'h02);
		rd(ADDR_MULT, 9'h000);
		chk("unlocked", 0, multiplier_locked);
		gap(0, MAIN_OSC_CYC);
		pwr(ADDR_PCC, 8'he9);
		repeat (SUB_CYC + 10) @(posedge core_clk);
		rd(ADDR_PCC, 9'h0f9);
		chk("main_stopped", 0, main_osc_enable);
		gap(1, SUB_CYC);
		gap(3, SUB_CYC);
		pwr(ADDR_PCC, 8'ha9);
		// Main oscillator settles before the CPU goes back to it
		repeat (200) @(posedge core_clk);
		chk("main_restart", 1, main_osc_enable);
		pwr(ADDR_PCC, 8'ha1);
		repeat (SUB_CYC + 10) @(posedge core_clk);
		rd(ADDR_PCC, 9'h0a1);
		chk("main_back", 1, main_osc_enable);
		gap(2, MAIN_OSC_CYC * WATCH_DIV);
		wr(ADDR_IOSC, 8'h01);
		rd(ADDR_IOSC, 9'h001);
		chk("int_stopped", 0, internal_osc_enable);
		wdt_stab_overflow <= 1'b1;
		@(posedge core_clk);
		wdt_stab_overflow <= 1'b0;
		rd(ADDR_OPST, 9'h001);
		rd(ADDR_IOSC, 9'h001);
		chk("int_kept", 1, internal_osc_enable);
		gap(1, INT_OSC_CYC);
		pstrb <= 4'he;
		wr(ADDR_OUTCTL, 8'h01);
		pstrb <= 4'hf;
		rd(ADDR_OUTCTL, 9'h000);
		wr(ADDR_OUTCTL, 8'h01);
		rd(ADDR_OUTCTL, 9'h001);
		n = 0;
		pin_prev = clock_output_pin;
		repeat (2000) begin
			@(posedge core_clk);
			n += int'(clock_output_pin != pin_prev);
			pin_prev = clock_output_pin;
		end
		chk("pin_driven", 0, clock_output_pin_oe_n);
		chk("pin_toggles", 1, n > 0);
		stop_mode <= 1'b1;
		repeat (6) @(posedge core_clk);
		chk("stop_main", 0, main_osc_enable);
		stop_mode <= 1'b0;
		repeat (4) @(posedge core_clk);
		end_of_test();
	end
endmodule
